// ==== rtl/qdc_pkg.sv ====
// Constants and types shared by the quad converter command decoder
package qdc_pkg;
  localparam int CH_N = 4;
  localparam int DATA_W = 8;
  localparam int REG_W = 10;
  // Command byte field positions
  localparam int CMD_ADDR_HI = 7;
  localparam int CMD_ADDR_LO = 6;
  localparam int CMD_LOAD_HI = 5;
  localparam int CMD_LOAD_LO = 4;
  localparam int CMD_CH_HI = 2;
  localparam int CMD_CH_LO = 1;
  localparam int CMD_PD = 0;
  // Power-down code position in the first data byte
  localparam int PDC_HI = 7;
  localparam int PDC_LO = 6;
  // Power-down code position in the 10-bit temporary and converter registers
  localparam int REG_PD_HI = 9;
  localparam int REG_PD_LO = 8;
  // Load field encodings and the normal power-down code
  localparam logic [1:0] LOAD_TEMP = 2'h0;
  localparam logic [1:0] LOAD_ONE = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;
  localparam logic [1:0] LOAD_BCAST = 2'h3;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [9:0] REG_RST = 10'h000;
  // Byte phase within a data pair
  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10
  } qdc_phase_e;
endpackage

// ==== rtl/qdc_decoder.sv ====
// Command decoder and channel registers of a quad 8-bit converter
`timescale 1ns/1ps
// Notes on behaviour
// - Load 00, data: write selected temporary register
// - Load 01, power-down: selected converter only
// - Load 10, data: write temp, load all converters
// - Broadcast, select high 0: load all from temps
// - Broadcast, select high 1: all channels get data
// - Broadcast power-down, select high 1: power down every channel
// - First data byte is unsigned conversion code
// - Power-down code is bits 7 and 6
// - Second data byte is ignored entirely
// - Updates happen at acknowledge after second byte
// - Power-on reset clears readback storage to zero
// - Update pin rising edge copies all temps
// - Command byte held; governs following data bytes
// - Per-channel 10-bit temp: code over data
// - Per-channel 10-bit converter; load changes output
// - High byte store holds data or code
// - Power-down flag 0 normal, 1 power-down
// - Data pairs repeat until stop or restart
module qdc_decoder
  import qdc_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Link side, from the serial slave framing logic
  input wire logic lnk_clk,
  input wire logic lnk_cmd_stb,
  input wire logic lnk_data_stb,
  input wire logic [7:0] lnk_byte,
  input wire logic lnk_ack_fall,
  input wire logic lnk_frame_end,
  // Pins
  input wire logic addr_pin_upper,
  input wire logic addr_pin_lower,
  input wire logic ext_update_pin,
  // Converter registers, readback
  output logic [9:0] conv_reg_a,
  output logic [9:0] conv_reg_b,
  output logic [9:0] conv_reg_c,
  output logic [9:0] conv_reg_d,
  output logic [7:0] command_byte_store,
  output logic [7:0] high_data_store
);

  typedef struct packed {
    logic [1:0] addr_s1;
    logic [1:0] addr_s2;
    logic [7:0] cmd;
    logic cmd_ok;
    logic [7:0] msb;
    qdc_phase_e phase;
    logic pair_done;
    logic [7:0] req_cmd;
    logic [7:0] req_msb;
    logic req_tgl;
  } qdc_lnk_s;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic upd_s1;
    logic upd_s2;
    logic upd_s3;
    logic [3:0][9:0] temp;
    logic [3:0][9:0] conv;
  } qdc_core_s;

  localparam qdc_lnk_s LNK_RST = '{addr_s1: 2'h0, addr_s2: 2'h0, cmd: BYTE_RST, cmd_ok: 1'b0,
    msb: BYTE_RST, phase: PH_HIGH, pair_done: 1'b0, req_cmd: BYTE_RST, req_msb: BYTE_RST, req_tgl: 1'b0};
  localparam qdc_core_s CORE_RST = '{tgl_s1: 1'b0, tgl_s2: 1'b0, tgl_s3: 1'b0, upd_s1: 1'b0,
    upd_s2: 1'b0, upd_s3: 1'b0, temp: {CH_N{REG_RST}}, conv: {CH_N{REG_RST}}};

  qdc_lnk_s lnk_ff;
  qdc_lnk_s nxt_lnk;
  qdc_core_s core_ff;
  qdc_core_s nxt_core;

  // ---------------- Link domain ----------------
  logic cmd_bcast;
  assign cmd_bcast = (lnk_byte[CMD_LOAD_HI:CMD_LOAD_LO] == LOAD_BCAST);

  always_comb begin
    nxt_lnk = lnk_ff;
    // Address straps are pins, so they are synchronised before the match
    nxt_lnk.addr_s1 = {addr_pin_upper, addr_pin_lower};
    nxt_lnk.addr_s2 = lnk_ff.addr_s1;
    if (lnk_frame_end) begin
      // Stop or repeated start closes the data stream
      nxt_lnk.cmd_ok = 1'b0;
      nxt_lnk.phase = PH_HIGH;
      nxt_lnk.pair_done = 1'b0;
    end else if (lnk_cmd_stb) begin
      nxt_lnk.cmd = lnk_byte;
      // Bit 3 takes no part in the match
      nxt_lnk.cmd_ok = cmd_bcast || (lnk_byte[CMD_ADDR_HI:CMD_ADDR_LO] == lnk_ff.addr_s2);
      nxt_lnk.phase = PH_HIGH;
      nxt_lnk.pair_done = 1'b0;
    end else if (lnk_data_stb && lnk_ff.cmd_ok) begin
      case (lnk_ff.phase)
        PH_HIGH: begin
          nxt_lnk.msb = lnk_byte;
          nxt_lnk.phase = PH_LOW;
        end
        PH_LOW: begin
          // Low byte content is never looked at
          nxt_lnk.phase = PH_HIGH;
          nxt_lnk.pair_done = 1'b1;
        end
        default: begin
          nxt_lnk.phase = PH_HIGH;
        end
      endcase
    end else if (lnk_ack_fall && lnk_ff.pair_done) begin
      nxt_lnk.req_cmd = lnk_ff.cmd;
      nxt_lnk.req_msb = lnk_ff.msb;
      nxt_lnk.req_tgl = ~lnk_ff.req_tgl;
      nxt_lnk.pair_done = 1'b0;
      // A power-down command takes one pair only; data pairs repeat
      if (lnk_ff.cmd[CMD_PD]) begin
        nxt_lnk.cmd_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge lnk_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_ff <= LNK_RST;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ---------------- Core domain ----------------
  // Request words are held in the link domain until the next pair, far longer than the crossing takes
  logic upd_req;
  logic ext_update_pin_rise;
  logic [1:0] u_load;
  logic [1:0] u_ch;
  logic u_pd;
  logic [1:0] u_code;
  logic [9:0] u_val;
  assign upd_req = core_ff.tgl_s2 ^ core_ff.tgl_s3;
  assign ext_update_pin_rise = core_ff.upd_s2 & ~core_ff.upd_s3;
  assign u_load = lnk_ff.req_cmd[CMD_LOAD_HI:CMD_LOAD_LO];
  assign u_ch = lnk_ff.req_cmd[CMD_CH_HI:CMD_CH_LO];
  assign u_pd = lnk_ff.req_cmd[CMD_PD];
  assign u_code = lnk_ff.req_msb[PDC_HI:PDC_LO];

  always_comb begin
    nxt_core = core_ff;
    nxt_core.tgl_s1 = lnk_ff.req_tgl;
    nxt_core.tgl_s2 = core_ff.tgl_s1;
    nxt_core.tgl_s3 = core_ff.tgl_s2;
    // Two flops before the edge detector; the third only remembers the last level
    nxt_core.upd_s1 = ext_update_pin;
    nxt_core.upd_s2 = core_ff.upd_s1;
    nxt_core.upd_s3 = core_ff.upd_s2;
    // Power-down keeps the stored data bits under the new code
    u_val = u_pd ? {u_code, core_ff.temp[u_ch][DATA_W-1:0]} : {PD_NORMAL, lnk_ff.req_msb};
    if (upd_req) begin
      case (u_load)
        LOAD_TEMP: begin
          nxt_core.temp[u_ch] = u_val;
        end
        LOAD_ONE: begin
          if (u_pd) begin
            nxt_core.conv[u_ch] = {u_code, core_ff.conv[u_ch][DATA_W-1:0]};
          end else begin
            nxt_core.temp[u_ch] = u_val;
            nxt_core.conv[u_ch] = u_val;
          end
        end
        LOAD_ALL: begin
          nxt_core.temp[u_ch] = u_val;
          nxt_core.conv = nxt_core.temp;
        end
        LOAD_BCAST: begin
          for (int i = 0; i < CH_N; i++) begin
            if (!u_ch[1]) begin
              nxt_core.conv[i] = core_ff.temp[i];
            end else if (!u_pd) begin
              nxt_core.temp[i] = {PD_NORMAL, lnk_ff.req_msb};
              nxt_core.conv[i] = {PD_NORMAL, lnk_ff.req_msb};
            end else begin
              nxt_core.conv[i] = {u_code, core_ff.conv[i][DATA_W-1:0]};
            end
          end
        end
        default: begin
          nxt_core.temp = core_ff.temp;
        end
      endcase
    end
    // Pin edge wins over a serial load in the same cycle and sees its temps
    if (ext_update_pin_rise) begin
      nxt_core.conv = nxt_core.temp;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ff <= CORE_RST;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign conv_reg_a = core_ff.conv[0];
  assign conv_reg_b = core_ff.conv[1];
  assign conv_reg_c = core_ff.conv[2];
  assign conv_reg_d = core_ff.conv[3];
  assign command_byte_store = lnk_ff.cmd;
  assign high_data_store = lnk_ff.msb;

  // ---------------- Assertions ----------------
  addr_gate_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_cmd_stb && !lnk_frame_end && !cmd_bcast && lnk_byte[CMD_ADDR_HI:CMD_ADDR_LO] != lnk_ff.addr_s2
    |=> !lnk_ff.cmd_ok)
    else $error("Command accepted with wrong address bits");

  pair_req_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_ack_fall && lnk_ff.pair_done && !lnk_frame_end && !lnk_cmd_stb && !lnk_data_stb
    |=> lnk_ff.req_tgl != $past(lnk_ff.req_tgl) && lnk_ff.req_msb == $past(lnk_ff.msb))
    else $error("Completed pair did not raise an update");

  temp_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_TEMP && !u_pd |=> core_ff.temp[$past(u_ch)] == {PD_NORMAL, $past(lnk_ff.req_msb)})
    else $error("Temporary register not written with data");

  pd_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_TEMP && !ext_update_pin_rise |=> core_ff.conv == $past(core_ff.conv))
    else $error("Converter changed on temporary-only write");

  one_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_ONE && !u_pd |=> core_ff.conv[$past(u_ch)] == {PD_NORMAL, $past(lnk_ff.req_msb)})
    else $error("Selected converter not loaded");

  all_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_ALL |=> core_ff.conv == core_ff.temp)
    else $error("Converters differ from temps after load all");

  bcast_pd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_BCAST && u_ch[1] && u_pd && !ext_update_pin_rise
    |=> core_ff.conv[0][REG_PD_HI:REG_PD_LO] == $past(u_code) && core_ff.conv[3][REG_PD_HI:REG_PD_LO] == $past(u_code))
    else $error("Broadcast power-down missed a channel");

  pin_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(core_ff.upd_s2) |=> core_ff.conv == core_ff.temp)
    else $error("Update pin edge did not copy temps");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !upd_req && !ext_update_pin_rise |=> $stable(core_ff.conv) && $stable(core_ff.temp))
    else $error("Registers changed without a cause");

  cross_time_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lnk_ff.req_tgl != core_ff.tgl_s1 |-> ##[1:3] upd_req)
    else $error("Update request not seen in time");

  // Link-side checks
  cmd_hold_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_cmd_stb && !lnk_frame_end |=> lnk_ff.cmd == $past(lnk_byte))
    else $error("Command byte not held");

  msb_take_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_data_stb && !lnk_frame_end && !lnk_cmd_stb && lnk_ff.cmd_ok && lnk_ff.phase == PH_HIGH
    |=> lnk_ff.msb == $past(lnk_byte) && lnk_ff.phase == PH_LOW)
    else $error("High data byte not stored");

  low_skip_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_data_stb && !lnk_frame_end && !lnk_cmd_stb && lnk_ff.cmd_ok && lnk_ff.phase == PH_LOW
    |=> $stable(lnk_ff.msb) && lnk_ff.pair_done)
    else $error("Low data byte was not ignored");

  refuse_data_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_data_stb && !lnk_frame_end && !lnk_cmd_stb && !lnk_ff.cmd_ok
    |=> $stable(lnk_ff.msb) && !lnk_ff.pair_done)
    else $error("Data taken for a refused command");

  frame_close_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_frame_end |=> !lnk_ff.cmd_ok && !lnk_ff.pair_done && lnk_ff.phase == PH_HIGH)
    else $error("Frame end did not close the stream");

  pd_single_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_ack_fall && lnk_ff.pair_done && lnk_ff.cmd[CMD_PD] && !lnk_frame_end && !lnk_cmd_stb && !lnk_data_stb
    |=> !lnk_ff.cmd_ok)
    else $error("Power-down command accepted a second pair");

  ack_ignore_a: assert property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_ack_fall && !lnk_ff.pair_done |=> $stable(lnk_ff.req_tgl))
    else $error("Update raised without a complete pair");

  // Core-side checks; request words stay stable while upd_req is high
  one_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_ONE && !u_pd |=> core_ff.temp[$past(u_ch)] == {PD_NORMAL, $past(lnk_ff.req_msb)})
    else $error("Temporary register not written with its converter");

  one_pd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_ONE && u_pd && !ext_update_pin_rise
    |=> core_ff.conv[$past(u_ch)][REG_PD_HI:REG_PD_LO] == $past(u_code) && core_ff.temp == $past(core_ff.temp))
    else $error("Power-down did not reach the selected converter only");

  all_pd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    upd_req && u_load == LOAD_ALL && u_pd |=> core_ff.conv[$past(u_ch)][REG_PD_HI:REG_PD_LO] == $past(u_code))
    else $error("Power-down code not loaded with all channels");

  // Reset release must leave the readback at zero
  reset_zero_a: assert property (@(posedge ref_clk)
    $rose(rst_b) |-> core_ff.conv == '0 && core_ff.temp == '0)
    else $error("Registers not zero after reset");

  // Broadcast checks repeat per channel
  for (genvar g = 0; g < CH_N; g++) begin : g_bcast
    bcast_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      upd_req && u_load == LOAD_BCAST && !u_ch[1] |=> core_ff.conv[g] == $past(core_ff.temp[g]))
      else $error("Broadcast load missed a channel");

    bcast_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      upd_req && u_load == LOAD_BCAST && u_ch[1] && !u_pd
      |=> core_ff.conv[g] == {PD_NORMAL, $past(lnk_ff.req_msb)} && core_ff.temp[g] == core_ff.conv[g])
      else $error("Broadcast data missed a channel");

    bcast_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      upd_req && u_load == LOAD_BCAST && u_ch[1] && u_pd && !ext_update_pin_rise
      |=> core_ff.conv[g][DATA_W-1:0] == $past(core_ff.conv[g][DATA_W-1:0]) && $stable(core_ff.temp[g]))
      else $error("Broadcast power-down disturbed stored data");
  end

  bcast_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) upd_req && u_load == LOAD_BCAST);
  pd_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) upd_req && u_pd);
  pin_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) ext_update_pin_rise);
  data_bc_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) upd_req && u_load == LOAD_BCAST && u_ch[1] && !u_pd);
  repeat_cov: cover property (@(posedge lnk_clk) disable iff (!rst_b)
    lnk_ack_fall && lnk_ff.pair_done ##[1:40] lnk_ack_fall && lnk_ff.pair_done);

endmodule

// ==== tb/qdc_link_model.sv ====
// Link-side model: frames of command byte and data pairs
`timescale 1ns/1ps
module qdc_link_model (
  // Link clock
  input wire logic lnk_clk,
  // Byte strobes and framing
  output logic lnk_cmd_stb,
  output logic lnk_data_stb,
  output logic [7:0] lnk_byte,
  output logic lnk_ack_fall,
  output logic lnk_frame_end
);
  initial begin
    {lnk_frame_end, lnk_cmd_stb, lnk_data_stb, lnk_ack_fall} = 4'h0;
    lnk_byte = 8'h00;
  end
  // One-cycle strobe; afterwards the byte shows its inverse, never a stale value
  task step(input logic [3:0] s, input logic [7:0] b);
    @(posedge lnk_clk);
    {lnk_frame_end, lnk_cmd_stb, lnk_data_stb, lnk_ack_fall} <= s;
    lnk_byte <= b;
    @(posedge lnk_clk);
    {lnk_frame_end, lnk_cmd_stb, lnk_data_stb, lnk_ack_fall} <= 4'h0;
    lnk_byte <= ~b;
  endtask
  task send(input logic [7:0] c, input logic [7:0] d, input int n);
    step(4'h4, c);
    for (int i = 0; i < n; i++) begin
      step(4'h2, d + i[7:0]);
      step(4'h2, ~d);
      step(4'h1, 8'h00);
      // Gap keeps update requests far enough apart for the core clock
      repeat (4) @(posedge lnk_clk);
    end
    step(4'h8, 8'h00);
  endtask
endmodule

// ==== tb/tb_qdc_decoder.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_qdc_decoder;
  import qdc_pkg::*;
  logic ref_clk, lnk_clk, rst_b, pu, pl, upd;
  logic cs, ds, af, fe;
  logic [7:0] lb, cbs, hds;
  logic [9:0] cr [4];
  logic [9:0] tmp [4];
  logic [9:0] cv [4];
  int n_mismatch = 0;
  int check_count = 0;
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Phase offset keeps the two clocks unrelated
  initial begin
    lnk_clk = 0;
    #3;
    forever #7.5 lnk_clk = ~lnk_clk;
  end
  qdc_link_model lm_u (.lnk_clk(lnk_clk), .lnk_cmd_stb(cs), .lnk_data_stb(ds), .lnk_byte(lb),
    .lnk_ack_fall(af), .lnk_frame_end(fe));
  qdc_decoder dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .lnk_clk(lnk_clk), .lnk_cmd_stb(cs),
    .lnk_data_stb(ds), .lnk_byte(lb), .lnk_ack_fall(af), .lnk_frame_end(fe), .addr_pin_upper(pu),
    .addr_pin_lower(pl), .ext_update_pin(upd), .conv_reg_a(cr[0]), .conv_reg_b(cr[1]),
    .conv_reg_c(cr[2]), .conv_reg_d(cr[3]), .command_byte_store(cbs), .high_data_store(hds));
  task finish_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Updates land a few core cycles after the link pulse; sample away from the launching edge
  task settle_chk;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    for (int i = 0; i < 4; i++) cmp(cr[i], cv[i]);
  endtask
  task op(input logic [7:0] c, input logic [7:0] d, input int n);
    logic ok;
    logic [1:0] k;
    logic [7:0] v;
    ok = c[5:4] == LOAD_BCAST || c[7:6] == {pu, pl};
    k = c[2:1];
    v = d;
    lm_u.send(c, d, n);
    for (int j = 0; j < n && ok; j++) begin
      v = d + j[7:0];
      case (c[5:4])
        LOAD_TEMP: if (c[0]) tmp[k][9:8] = v[7:6]; else tmp[k] = {2'b00, v};
        LOAD_ONE: if (c[0]) cv[k][9:8] = v[7:6]; else begin tmp[k] = {2'b00, v}; cv[k] = tmp[k]; end
        LOAD_ALL: begin
          if (c[0]) tmp[k][9:8] = v[7:6]; else tmp[k] = {2'b00, v};
          cv = tmp;
        end
        default: for (int i = 0; i < 4; i++)
          if (!c[2]) cv[i] = tmp[i];
          else if (c[0]) cv[i][9:8] = v[7:6];
          else begin tmp[i] = {2'b00, v}; cv[i] = tmp[i]; end
      endcase
    end
    settle_chk;
    if (ok) begin
      cmp({2'b00, cbs}, {2'b00, c});
      cmp({2'b00, hds}, {2'b00, v});
    end
  endtask
  initial begin
    rst_b = 0;
    pu = 1;
    pl = 0;
    upd = 0;
    tmp = '{default: 10'h000};
    cv = '{default: 10'h000};
    repeat (6) @(posedge ref_clk);
    rst_b <= 1;
    repeat (4) @(posedge lnk_clk);
    settle_chk;
    for (int i = 0; i < 4; i++) op({4'h8, 1'b1, i[1:0], 1'b0}, 8'h10 + i[7:0], 1);
    op(8'h92, 8'h5a, 1);
    op(8'ha4, 8'hc3, 2);
    op(8'h81, 8'h80, 1);
    @(posedge ref_clk);
    upd <= 1;
    cv = tmp;
    settle_chk;
    @(posedge ref_clk);
    upd <= 0;
    op(8'h97, 8'h40, 1);
    op(8'ha3, 8'hc0, 1);
    op(8'h52, 8'h77, 1);
    op(8'h8c, 8'h21, 1);
    op(8'h80, 8'h66, 1);
    op(8'h73, 8'hff, 1);
    op(8'h36, 8'h33, 2);
    op(8'hf5, 8'h40, 1);
    // Mid-run reset must clear converters and readback again
    @(posedge ref_clk);
    rst_b <= 0;
    cv = '{default: 10'h000};
    repeat (6) @(posedge ref_clk);
    rst_b <= 1;
    settle_chk;
    cmp({2'b00, cbs}, 10'h000);
    cmp({2'b00, hds}, 10'h000);
    finish_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
endmodule
